//--- rtl/pwm_capture_quadrature_unit.sv
// compare/pwm with deadband, capture fifos and quadrature decoder
`include "pcq_params.svh"
`timescale 1ns/1ns
`default_nettype none

module pwm_capture_quadrature_unit
(
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_b,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // pins from outside
   input  wire logic [2:0]  i_capture_input_pin,
   input  wire logic        i_power_drive_protect_in_b,
   input  wire logic        i_timer2_compare_trip_b,
   // pwm pins
   output logic      [5:0]  o_pwm,
   output logic      [5:0]  o_pwm_oe,
   output logic      [1:0]  o_tpwm,
   output logic      [1:0]  o_tpwm_oe,
   // conversion start pin (shared with timer 2 trip) and capture request
   output logic             o_conv_start_out_a,
   output logic             o_conv_start_out_a_oe,
   output logic             o_cap_req
);

   //==========================================================
   // state and helpers
   pcq_pkg::state_type s_reg;
   pcq_pkg::state_type s_next;
   logic               t1_uf;
   logic               t1_pr;
   logic               rld;
   logic [2:0]         cap_ev;
   logic [2:0]         raw;

   // one step of an up or up/down counter, returns {dir, count}
   function automatic logic [16:0] timer_step(input logic [15:0] c, input logic d,
                                              input logic [15:0] p, input logic ud);
      logic        nd;
      logic [15:0] nc;
      nd = d;
      if (ud)
      begin
         if (c == 16'h0000)
            nd = 1'b1;
         else if (c >= p)
            nd = 1'b0;
         nc = nd ? c + 16'h0001 : c - 16'h0001;
      end
      else
      begin
         nd = 1'b1;
         nc = (c >= p) ? 16'h0000 : c + 16'h0001;
      end
      return {nd, nc};
   endfunction

   // action code: 0 forced low, 1 active low, 2 active high, 3 forced high
   function automatic logic polar(input logic x, input logic [1:0] code);
      return code[1] ? (code[0] | x) : (code[0] & ~x);
   endfunction

   //==========================================================
   // next state
   always_comb
   begin
      logic [4:0]  rise;
      logic [4:0]  fall;
      logic [4:0]  qchg;
      logic [16:0] ts;
      logic [15:0] tb;
      logic [2:0]  clr;
      logic [1:0]  es;
      logic        hold;
      logic        qa;
      logic        qb;
      logic        up;
      rise   = 5'h00;
      fall   = 5'h00;
      ts     = 17'h00000;
      tb     = 16'h0000;
      clr    = 3'h0;
      es     = 2'h0;
      hold   = 1'b0;
      up     = 1'b0;
      qchg   = 5'h00;
      qa     = 1'b0;
      qb     = 1'b0;
      cap_ev = 3'h0;
      raw    = 3'h0;
      s_next = s_reg;

      // three-stage sync, level taken once stages two and three agree
      s_next.sync1 = {i_timer2_compare_trip_b, i_power_drive_protect_in_b,
                      i_capture_input_pin};
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;
      for (int k = 0; k < 5; k++)
      begin
         if (s_reg.sync2[k] == s_reg.sync3[k])
            s_next.qual[k] = s_reg.sync3[k];
      end
      qchg = s_next.qual ^ s_reg.qual;
      rise = qchg & s_next.qual;
      fall = qchg & ~s_next.qual;

      // timer 1: time base of all compare units
      t1_uf = s_reg.t1ctl[`PCQ_TCTL_EN] && s_reg.t1cnt == 16'h0000;
      t1_pr = s_reg.t1ctl[`PCQ_TCTL_EN] && s_reg.t1cnt == s_reg.t1prd;
      if (s_reg.t1ctl[`PCQ_TCTL_EN])
      begin
         ts = timer_step(s_reg.t1cnt, s_reg.t1dir, s_reg.t1prd,
                         s_reg.t1ctl[`PCQ_TCTL_UD]);
         s_next.t1dir = ts[16];
         s_next.t1cnt = ts[15:0];
      end
      if (t1_uf)
      begin
         s_next.t1prd = s_reg.t1prd_sh;
         s_next.t1cmp = s_reg.t1cmp_sh;
      end

      // timer 2: free counter or quadrature position counter
      qa = s_next.qual[0];
      qb = s_next.qual[1];
      if (s_reg.capctl[`PCQ_CAP_QEP])
      begin
         // A-leads-B counts up; a double change in one cycle is dropped
         up = qchg[0] ? (qa != qb) : (qa == qb);
         if (qchg[0] ^ qchg[1])
            s_next.t2cnt = up ? s_reg.t2cnt + 16'h0001 : s_reg.t2cnt - 16'h0001;
      end
      else if (s_reg.t2ctl[`PCQ_TCTL_EN])
      begin
         ts = timer_step(s_reg.t2cnt, s_reg.t2dir, s_reg.t2prd,
                         s_reg.t2ctl[`PCQ_TCTL_UD]);
         s_next.t2dir = ts[16];
         s_next.t2cnt = ts[15:0];
      end
      if (s_reg.ext[`PCQ_EXT_IDX] && rise[2])
         s_next.t2cnt = 16'h0000;
      if (s_reg.t2cnt == 16'h0000)
      begin
         s_next.t2prd = s_reg.t2prd_sh;
         s_next.t2cmp = s_reg.t2cmp_sh;
      end

      // compare and action reload from their buffers
      unique case (pcq_pkg::reload_type'(s_reg.cmpctl[`PCQ_CMP_RLD +: 2]))
         pcq_pkg::RLD_UF:   rld = t1_uf;
         pcq_pkg::RLD_UFPR: rld = t1_uf | t1_pr;
         pcq_pkg::RLD_NOW:  rld = 1'b1;
         default:           rld = 1'b0;
      endcase
      if (rld)
      begin
         s_next.cmp = s_reg.cmp_sh;
         s_next.act = s_reg.act_sh;
      end

      // compare units with deadband pairs, timer 1 based
      for (int u = 0; u < 3; u++)
      begin
         raw[u] = s_reg.cmpctl[`PCQ_CMP_EN] && (s_reg.t1cnt < s_reg.cmp[u]);
         if (raw[u] != s_reg.raw_prev[u])
         begin
            s_next.raw_prev[u] = raw[u];
            s_next.db_cnt[u] = s_reg.dbctl[`PCQ_DB_EN + u] ? s_reg.dbctl[7:0] : 8'h00;
         end
         else if (s_reg.db_cnt[u] != 8'h00)
            s_next.db_cnt[u] = s_reg.dbctl[`PCQ_DB_EN + u] ? s_reg.db_cnt[u] - 8'h01 : 8'h00;
         // both inactive while the gap runs; no gap leaves them switching together
         hold = s_next.db_cnt[u] != 8'h00;
         s_next.pwm[2*u] = polar(raw[u] & ~hold, s_reg.act[4*u +: 2]);
         s_next.pwm[2*u+1] = polar(~raw[u] & ~hold, s_reg.act[4*u+2 +: 2]);
         // protect trip releases the pins of every pair that has it enabled
         s_next.pwm_oe[2*u +: 2] = {2{s_reg.cmpctl[`PCQ_CMP_EN]
                                   && !(!s_reg.qual[3] && s_reg.ext[u])}};
      end

      // timer compare pwms, active high
      s_next.tpwm[0] = s_reg.t1cnt < s_reg.t1cmp;
      s_next.tpwm[1] = s_reg.t2cnt < s_reg.t2cmp;
      s_next.tpwm_oe[0] = s_reg.t1ctl[`PCQ_TCTL_CMPEN] && !(!s_reg.qual[3] && s_reg.ext[3]);
      // shared pin trips timer 2 output only while not used for conversion start
      s_next.tpwm_oe[1] = s_reg.t2ctl[`PCQ_TCTL_CMPEN] && !(!s_reg.qual[3] && s_reg.ext[3])
                          && !(!s_reg.qual[4] && !s_reg.ext[`PCQ_EXT_SOC]);

      // conversion start on timer 1 period match, routed to the pin
      s_next.soc = s_reg.ext[`PCQ_EXT_SOC] && t1_pr;
      s_next.soc_oe = s_reg.ext[`PCQ_EXT_SOC];

      // capture fifo pops by reading the fifo word
      for (int u = 0; u < 3; u++)
      begin
         if (i_rd && i_addr == `PCQ_A_CAPF1 + u[7:0] && s_reg.fcount[u] != 2'h0)
         begin
            s_next.fifo[u][0] = s_reg.fifo[u][1];
            s_next.fcount[u] = (s_reg.fcount[u] == 2'h2) ? 2'h1 : 2'h0;
            if (s_reg.fcount[u] == 2'h3)
               s_next.fcount[u] = 2'h1;
         end
      end

      // capture events; quadrature inputs give no captures
      tb = s_reg.capctl[`PCQ_CAP_TB] ? s_reg.t1cnt : s_reg.t2cnt;
      for (int u = 0; u < 3; u++)
      begin
         es = s_reg.capctl[`PCQ_CAP_EDGE + 2*u +: 2];
         cap_ev[u] = ((es[0] && rise[u]) || (es[1] && fall[u]))
                     && !(s_reg.capctl[`PCQ_CAP_QEP] && u < 2);
         if (cap_ev[u] && s_reg.capctl[u])
         begin
            unique case (s_next.fcount[u])
               2'h0:
               begin
                  s_next.fifo[u][0] = tb;
                  s_next.fcount[u] = 2'h1;
               end
               2'h1:
               begin
                  s_next.fifo[u][1] = tb;
                  s_next.fcount[u] = 2'h2;
               end
               default:
               begin
                  // full: oldest entry lost, status shows overrun
                  s_next.fifo[u][0] = s_next.fifo[u][1];
                  s_next.fifo[u][1] = tb;
                  s_next.fcount[u] = 2'h3;
               end
            endcase
         end
      end

      // register writes; software wins over the hardware counters
      if (i_wr)
      begin
         unique case (i_addr)
            `PCQ_A_T1CNT:  s_next.t1cnt = i_wdata;
            `PCQ_A_T1CMP:  s_next.t1cmp_sh = i_wdata;
            `PCQ_A_T1PRD:  s_next.t1prd_sh = i_wdata;
            `PCQ_A_T1CTL:  s_next.t1ctl = i_wdata[2:0];
            `PCQ_A_T2CNT:  s_next.t2cnt = i_wdata;
            `PCQ_A_T2CMP:  s_next.t2cmp_sh = i_wdata;
            `PCQ_A_T2PRD:  s_next.t2prd_sh = i_wdata;
            `PCQ_A_T2CTL:  s_next.t2ctl = i_wdata[2:0];
            `PCQ_A_EXT:    s_next.ext = i_wdata[5:0];
            `PCQ_A_CMPCTL: s_next.cmpctl = i_wdata;
            `PCQ_A_ACT:    s_next.act_sh = i_wdata;
            `PCQ_A_DB:     s_next.dbctl = i_wdata;
            `PCQ_A_CAPCTL: s_next.capctl = i_wdata;
            `PCQ_A_MASK:   s_next.mask = i_wdata[2:0];
            `PCQ_A_FLAG:   clr = i_wdata[2:0];
            default:
            begin
               if (i_addr >= `PCQ_A_CMP1 && i_addr < `PCQ_A_CMP1 + 8'h03)
                  s_next.cmp_sh[i_addr - `PCQ_A_CMP1] = i_wdata;
            end
         endcase
      end

      // flags: an event in the clearing cycle survives
      s_next.flags = (s_reg.flags & ~clr) | cap_ev;
      s_next.irq = |(s_next.flags & s_reg.mask);

      // read data, valid the cycle after the strobe only
      s_next.rdata = 16'h0000;
      if (i_rd)
      begin
         unique case (i_addr)
            `PCQ_A_T1CNT:   s_next.rdata = s_reg.t1cnt;
            `PCQ_A_T1CMP:   s_next.rdata = s_reg.t1cmp_sh;
            `PCQ_A_T1PRD:   s_next.rdata = s_reg.t1prd_sh;
            `PCQ_A_T1CTL:   s_next.rdata = {13'h0000, s_reg.t1ctl};
            `PCQ_A_T2CNT:   s_next.rdata = s_reg.t2cnt;
            `PCQ_A_T2CMP:   s_next.rdata = s_reg.t2cmp_sh;
            `PCQ_A_T2PRD:   s_next.rdata = s_reg.t2prd_sh;
            `PCQ_A_T2CTL:   s_next.rdata = {13'h0000, s_reg.t2ctl};
            `PCQ_A_EXT:     s_next.rdata = {10'h000, s_reg.ext};
            `PCQ_A_CMPCTL:  s_next.rdata = {s_reg.cmpctl[15:9], s_reg.qual[3],
                                            s_reg.cmpctl[7:0]};
            `PCQ_A_ACT:     s_next.rdata = s_reg.act_sh;
            `PCQ_A_DB:      s_next.rdata = s_reg.dbctl;
            `PCQ_A_CAPCTL:  s_next.rdata = s_reg.capctl;
            `PCQ_A_CAPSTAT: s_next.rdata = {10'h000, s_reg.fcount};
            `PCQ_A_MASK:    s_next.rdata = {13'h0000, s_reg.mask};
            `PCQ_A_FLAG:    s_next.rdata = {13'h0000, s_reg.flags};
            default:
            begin
               if (i_addr >= `PCQ_A_CMP1 && i_addr < `PCQ_A_CMP1 + 8'h03)
                  s_next.rdata = s_reg.cmp_sh[i_addr - `PCQ_A_CMP1];
               else if (i_addr >= `PCQ_A_CAPF1 && i_addr < `PCQ_A_CAPF1 + 8'h03)
                  s_next.rdata = s_reg.fifo[i_addr - `PCQ_A_CAPF1][0];
            end
         endcase
      end
   end

   //==========================================================
   // state register; unmapped reads return zero
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s_reg      <= '0;
         s_reg.ext  <= `PCQ_EXT_RST;
         s_reg.act  <= `PCQ_ACT_RST;
         s_reg.qual <= 5'h1f; // idle-high so no edge right after reset
         // sync stages idle high too, else a low pulse ripples into qual
         s_reg.sync1 <= 5'h1f;
         s_reg.sync2 <= 5'h1f;
         s_reg.sync3 <= 5'h1f;
      end
      else
         s_reg <= s_next;
   end

   // outputs straight from the state register
   assign o_rdata               = s_reg.rdata;
   assign o_pwm                 = s_reg.pwm;
   assign o_pwm_oe              = s_reg.pwm_oe;
   assign o_tpwm                = s_reg.tpwm;
   assign o_tpwm_oe             = s_reg.tpwm_oe;
   assign o_conv_start_out_a    = s_reg.soc;
   assign o_conv_start_out_a_oe = s_reg.soc_oe;
   assign o_cap_req             = s_reg.irq;

   //==========================================================
   // assertions and covers
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   a_trip_pair_hiz: assert property (!s_reg.qual[3] && s_reg.ext[0] |=> o_pwm_oe[1:0] == 2'h0)
      else $error("pair 0 driven during protect trip");
   a_pdp_readback: assert property (i_rd && i_addr == `PCQ_A_CMPCTL
                                    |=> o_rdata[8] == $past(s_reg.qual[3]))
      else $error("protect level not in bit 8");
   a_trip_per_pair: assert property (!s_reg.ext[1] && s_reg.cmpctl[`PCQ_CMP_EN]
                                     |=> o_pwm_oe[3:2] == 2'h3)
      else $error("pair 1 released without trip enable");
   a_capture_push: assert property (cap_ev[0] && s_reg.capctl[0] && s_reg.fcount[0] == 2'h0
                                    && !i_rd |=> s_reg.fcount[0] == 2'h1)
      else $error("capture not pushed");
   a_flag_set_wins: assert property (cap_ev[2] |=> s_reg.flags[2])
      else $error("capture flag lost");
   a_cmp_reload_now: assert property (s_reg.cmpctl[14:13] == 2'h2 && !i_wr
                                      |=> s_reg.cmp[0] == $past(s_reg.cmp_sh[0]))
      else $error("immediate reload missed");
   a_cmp_hold_period: assert property (s_reg.cmpctl[14:13] == 2'h0 && !t1_uf
                                       |=> $stable(s_reg.cmp))
      else $error("compare changed between underflows");
   a_pair_no_overlap: assert property ($past(s_reg.act[3:0]) == 4'ha
                                       |-> !(o_pwm[0] && o_pwm[1]))
      else $error("pair outputs both active");
   a_db_off_nogap: assert property (!s_reg.dbctl[`PCQ_DB_EN] |=> s_reg.db_cnt[0] == 8'h00)
      else $error("gap inserted with deadband off");
   a_soc_routed: assert property (s_reg.ext[`PCQ_EXT_SOC] && t1_pr |=> o_conv_start_out_a)
      else $error("conversion start not driven");

   c_capture_full: cover property (s_reg.fcount[2] == 2'h3);
   c_qep_down: cover property (s_reg.capctl[`PCQ_CAP_QEP] && s_next.t2cnt == s_reg.t2cnt - 16'h1);
   c_protect_trip: cover property (o_pwm_oe == 6'h00 && s_reg.cmpctl[`PCQ_CMP_EN]);
   c_deadband_gap: cover property (s_reg.db_cnt[1] != 8'h00);

endmodule
`default_nettype wire

//--- rtl/pcq_params.svh
// offsets, field positions, reset values of the pwm/capture/quadrature unit
`ifndef PCQ_PARAMS_SVH
`define PCQ_PARAMS_SVH
// register offsets (word index on the plain register port)
`define PCQ_A_T1CNT   8'h01
`define PCQ_A_T1CMP   8'h02
`define PCQ_A_T1PRD   8'h03
`define PCQ_A_T1CTL   8'h04
`define PCQ_A_T2CNT   8'h05
`define PCQ_A_T2CMP   8'h06
`define PCQ_A_T2PRD   8'h07
`define PCQ_A_T2CTL   8'h08
`define PCQ_A_EXT     8'h09
`define PCQ_A_CMPCTL  8'h11
`define PCQ_A_ACT     8'h13
`define PCQ_A_DB      8'h15
`define PCQ_A_CMP1    8'h17
`define PCQ_A_CAPCTL  8'h20
`define PCQ_A_CAPSTAT 8'h22
`define PCQ_A_CAPF1   8'h23
`define PCQ_A_MASK    8'h2c
`define PCQ_A_FLAG    8'h2f
// field positions
`define PCQ_TCTL_EN    0
`define PCQ_TCTL_UD    1
`define PCQ_TCTL_CMPEN 2
`define PCQ_CMP_EN     15
`define PCQ_CMP_RLD    13
`define PCQ_CMP_PDP    8
`define PCQ_DB_EN      8
`define PCQ_CAP_TB     3
`define PCQ_CAP_EDGE   4
`define PCQ_CAP_QEP    10
`define PCQ_EXT_SOC    4
`define PCQ_EXT_IDX    5
// reset values
`define PCQ_EXT_RST    6'h0f
`define PCQ_ACT_RST    16'h0000
`endif

//--- rtl/pcq_pkg.sv
// types of the pwm/capture/quadrature unit
package pcq_pkg;
   // compare reload condition
   typedef enum logic [1:0] {
      RLD_UF   = 2'h0,
      RLD_UFPR = 2'h1,
      RLD_NOW  = 2'h2,
      RLD_RSV  = 2'h3
   } reload_type;

   // whole state of the unit
   typedef struct packed {
      logic [4:0]             sync1;
      logic [4:0]             sync2;
      logic [4:0]             sync3;
      logic [4:0]             qual;
      logic [15:0]            t1cnt;
      logic                   t1dir;
      logic [15:0]            t1prd_sh;
      logic [15:0]            t1prd;
      logic [15:0]            t1cmp_sh;
      logic [15:0]            t1cmp;
      logic [2:0]             t1ctl;
      logic [15:0]            t2cnt;
      logic                   t2dir;
      logic [15:0]            t2prd_sh;
      logic [15:0]            t2prd;
      logic [15:0]            t2cmp_sh;
      logic [15:0]            t2cmp;
      logic [2:0]             t2ctl;
      logic [15:0]            cmpctl;
      logic [15:0]            act_sh;
      logic [15:0]            act;
      logic [15:0]            dbctl;
      logic [2:0][15:0]       cmp_sh;
      logic [2:0][15:0]       cmp;
      logic [2:0]             raw_prev;
      logic [2:0][7:0]        db_cnt;
      logic [15:0]            capctl;
      logic [2:0][1:0][15:0]  fifo;
      logic [2:0][1:0]        fcount;
      logic [2:0]             flags;
      logic [2:0]             mask;
      logic [5:0]             ext;
      logic [5:0]             pwm;
      logic [5:0]             pwm_oe;
      logic [1:0]             tpwm;
      logic [1:0]             tpwm_oe;
      logic                   soc;
      logic                   soc_oe;
      logic                   irq;
      logic [15:0]            rdata;
   } state_type;
endpackage

//--- sim/enc_gate_model.sv
// partner model: quadrature encoder, index, protect switch and gate drivers
`timescale 1ns/1ns
`default_nettype none

module enc_gate_model
(
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_b,
   // commands from the bench
   input  wire logic       i_step,
   input  wire logic       i_rev,
   input  wire logic       i_idx,
   input  wire logic       i_fault,
   // pwm pins of the block
   input  wire logic [5:0] i_pwm,
   input  wire logic [5:0] i_pwm_oe,
   // pins towards the block, and gate driver levels to the bench
   output logic      [2:0] o_cap,
   output logic            o_protect_b,
   output logic            o_trip_b,
   output logic      [5:0] o_gate
);
   logic [1:0] phase_reg;
   logic [2:0] hold_reg;

   // ==========================================
   // encoder phase counter
   // a step is refused while the last level still has to be held
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         phase_reg <= 2'h0;
         hold_reg  <= 3'h0;
      end
      else if (i_step && hold_reg == 3'h0)
      begin
         phase_reg <= i_rev ? phase_reg - 2'h1 : phase_reg + 2'h1;
         hold_reg  <= 3'h4;
      end
      else if (hold_reg != 3'h0)
      begin
         hold_reg <= hold_reg - 3'h1;
      end
   end

   // ==========================================
   // pin levels
   // gray order {b,a}: 00,01,11,10, so a leads b going forward
   assign o_cap[0]    = phase_reg[0] ^ phase_reg[1];
   assign o_cap[1]    = phase_reg[1];
   assign o_cap[2]    = i_idx;
   assign o_protect_b = ~i_fault;
   assign o_trip_b    = 1'b1; // trip line released, pulled up
   // gate driver inputs have pull-downs, so a released pin reads low
   assign o_gate      = i_pwm & i_pwm_oe;
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking bench of the pwm/capture/quadrature unit
`include "pcq_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
   `define CHECK_EQ(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
   logic        i_core_clk = 1'b0;
   logic        i_rst_b    = 1'b0;
   logic [7:0]  i_addr     = 8'h00;
   logic [15:0] i_wdata    = 16'h0000;
   logic        i_wr       = 1'b0;
   logic        i_rd       = 1'b0;
   logic        step       = 1'b0;
   logic        rev        = 1'b0;
   logic        idx        = 1'b0;
   logic        fault      = 1'b0;
   logic [15:0] o_rdata;
   logic [2:0]  cap;
   logic        protect_b;
   logic        trip_b;
   logic [5:0]  o_pwm;
   logic [5:0]  o_pwm_oe;
   logic [5:0]  gate;
   logic [1:0]  o_tpwm;
   logic [1:0]  o_tpwm_oe;
   logic        o_conv_start_out_a;
   logic        o_conv_start_out_a_oe;
   logic        o_cap_req;
   logic [15:0] d;
   logic        hit;
   int          num_errors = 0;
   int          checks     = 0;
   int          cyc        = 0;

   // ==========================================
   // clock, design and partner
   always #10 i_core_clk = ~i_core_clk;

   pwm_capture_quadrature_unit dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_capture_input_pin(cap), .i_power_drive_protect_in_b(protect_b),
      .i_timer2_compare_trip_b(trip_b), .o_pwm(o_pwm), .o_pwm_oe(o_pwm_oe),
      .o_tpwm(o_tpwm), .o_tpwm_oe(o_tpwm_oe), .o_conv_start_out_a(o_conv_start_out_a),
      .o_conv_start_out_a_oe(o_conv_start_out_a_oe), .o_cap_req(o_cap_req));

   enc_gate_model model_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_step(step),
      .i_rev(rev), .i_idx(idx), .i_fault(fault), .i_pwm(o_pwm), .i_pwm_oe(o_pwm_oe),
      .o_cap(cap), .o_protect_b(protect_b), .o_trip_b(trip_b), .o_gate(gate));

   // ==========================================
   // bus and pin tasks
   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1 v = o_rdata;
   endtask

   // hold plus three sync stages: eight clocks is ample
   task move(input logic backward, input int n);
      repeat (n)
      begin
         @(posedge i_core_clk);
         step <= 1'b1;
         rev  <= backward;
         @(posedge i_core_clk);
         step <= 1'b0;
         repeat (8) @(posedge i_core_clk);
      end
   endtask

   task test_done;
      if (num_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================
   // scenarios
   task t_reset_regs;
      rd(`PCQ_A_EXT, d);
      `CHECK_EQ(d, 16'h000f)
      rd(`PCQ_A_ACT, d);
      `CHECK_EQ(d, 16'h0000)
      rd(8'h3f, d);
      `CHECK_EQ(d, 16'h0000)
   endtask

   // timer 1 period 16, immediate reload, out0 forced high, out1 forced low
   task t_pwm_soc;
      wr(`PCQ_A_T1PRD, 16'h0010);
      wr(`PCQ_A_T1CNT, 16'h0000);
      wr(`PCQ_A_T1CMP, 16'h0008);
      wr(`PCQ_A_T1CTL, 16'h0005);
      wr(`PCQ_A_CMPCTL, 16'hc000);
      wr(`PCQ_A_ACT, 16'h0003);
      wr(`PCQ_A_EXT, 16'h001f);
      hit = 1'b0;
      for (int i = 0; i < 40 && !hit; i++)
      begin
         @(posedge i_core_clk);
         #1 hit = gate[0];
      end
      `CHECK_EQ(hit, 1'b1)
      `CHECK_EQ(gate[1], 1'b0)
      `CHECK_EQ(o_conv_start_out_a_oe, 1'b1)
      `CHECK_EQ(o_tpwm_oe, 2'h1)
      hit = 1'b0;
      for (int i = 0; i < 40 && !hit; i++)
      begin
         @(posedge i_core_clk);
         #1 hit = o_conv_start_out_a;
      end
      `CHECK_EQ(hit, 1'b1)
   endtask

   // one full timer 1 period of pair 0 and timer 1 pwm levels
   task count_pair(output int lo, output int hi, output int tp);
      lo = 0;
      hi = 0;
      tp = 0;
      repeat (17)
      begin
         @(posedge i_core_clk);
         #1;
         lo += (gate[1:0] == 2'h0);
         hi += (gate[1:0] == 2'h3);
         tp += o_tpwm[0];
      end
   endtask

   // pair 0 active high, compare at 8 of a 17-count period, gap 3
   task t_deadband;
      int lo;
      int hi;
      int tp;
      wr(`PCQ_A_CMP1, 16'h0008);
      wr(`PCQ_A_ACT, 16'h000a);
      repeat (20) @(posedge i_core_clk);
      count_pair(lo, hi, tp);
      `CHECK_EQ(lo, 0)
      `CHECK_EQ(hi, 0)
      `CHECK_EQ(tp, 8)
      wr(`PCQ_A_DB, 16'h0103);
      repeat (20) @(posedge i_core_clk);
      count_pair(lo, hi, tp);
      `CHECK_EQ(lo, 6)
      `CHECK_EQ(hi, 0)
   endtask

   task t_protect;
      `CHECK_EQ(o_pwm_oe, 6'h3f)
      fault <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      #1 `CHECK_EQ(o_pwm_oe, 6'h00)
      `CHECK_EQ(o_tpwm_oe, 2'h0)
      wr(`PCQ_A_EXT, 16'h001d);
      @(posedge i_core_clk);
      #1 `CHECK_EQ(o_pwm_oe, 6'h0c)
      rd(`PCQ_A_CMPCTL, d);
      `CHECK_EQ(d[8], 1'b0)
      wr(`PCQ_A_EXT, 16'h001f);
      fault <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      rd(`PCQ_A_CMPCTL, d);
      `CHECK_EQ(d[8], 1'b1)
   endtask

   // frozen time bases make the stamped value exact
   task t_capture;
      wr(`PCQ_A_T1CTL, 16'h0000);
      wr(`PCQ_A_T1CNT, 16'h1234);
      wr(`PCQ_A_CAPCTL, 16'h0019);
      move(1'b0, 1);
      rd(`PCQ_A_CAPSTAT, d);
      `CHECK_EQ(d[1:0], 2'h1)
      rd(`PCQ_A_FLAG, d);
      `CHECK_EQ(d[2:0], 3'h1)
      move(1'b0, 2);
      rd(`PCQ_A_CAPSTAT, d);
      `CHECK_EQ(d[1:0], 2'h1)
      rd(`PCQ_A_CAPF1, d);
      `CHECK_EQ(d, 16'h1234)
      wr(`PCQ_A_T2CNT, 16'h0abc);
      wr(`PCQ_A_CAPCTL, 16'h0031);
      move(1'b0, 2);
      rd(`PCQ_A_CAPF1, d);
      `CHECK_EQ(d, 16'h0abc)
      rd(`PCQ_A_CAPSTAT, d);
      `CHECK_EQ(d[1:0], 2'h0)
      wr(`PCQ_A_FLAG, 16'h0007);
      rd(`PCQ_A_FLAG, d);
      `CHECK_EQ(d[2:0], 3'h0)
   endtask

   task t_quadrature;
      wr(`PCQ_A_CAPCTL, 16'h0500);
      wr(`PCQ_A_T2CNT, 16'h0100);
      wr(`PCQ_A_T2CTL, 16'h0001);
      move(1'b0, 8);
      rd(`PCQ_A_T2CNT, d);
      `CHECK_EQ(d, 16'h0108)
      move(1'b1, 4);
      rd(`PCQ_A_T2CNT, d);
      `CHECK_EQ(d, 16'h0104)
      wr(`PCQ_A_EXT, 16'h002f);
      idx <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      rd(`PCQ_A_T2CNT, d);
      `CHECK_EQ(d, 16'h0000)
      rd(`PCQ_A_FLAG, d);
      `CHECK_EQ(d[2:0], 3'h4)
      rd(`PCQ_A_CAPSTAT, d);
      `CHECK_EQ(d[5:4], 2'h0)
      wr(`PCQ_A_MASK, 16'h0004);
      @(posedge i_core_clk);
      #1 `CHECK_EQ(o_cap_req, 1'b1)
   endtask

   // ==========================================
   // hang guard and main sequence
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         test_done;
      end
   end

   initial
   begin
      repeat (10) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      t_reset_regs;
      t_pwm_soc;
      t_deadband;
      t_protect;
      t_capture;
      t_quadrature;
      test_done;
   end
   `undef CHECK_EQ
endmodule
`default_nettype wire
